// ### vir_route_ctrl.sv
// Top: register bank, source routing, change interrupt and clock control
`timescale 1ns/1ps
`include "vir_params.svh"

module vir_route_ctrl
  import vir_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [`VIR_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [`VIR_NUM_SRC-1:0] irq_sources,
  output logic [`VIR_NUM_IRQ-1:0] irq_lines,
  output logic [`VIR_NUM_EVT-1:0] event_lines,
  output logic irq,
  output vir_prio_type table_priority,
  output vir_clk_out_type clock_enables
);

  typedef struct packed {
    vir_clk_ctrl_type clk_ctrl;
    vir_sel4_type irq_sel_b;
    logic [31:0] irq_sel_c;
    vir_sel4_type evt_sel;
    vir_prio_type prio;
    logic [`VIR_NUM_LINES-1:0] status;
    logic [`VIR_NUM_LINES-1:0] mask;
    logic [`VIR_NUM_LINES-1:0] lines_prev;
    logic wait_r;
    logic [31:0] rdata;
    logic irq_out;
  } vir_top_state_type;

  vir_top_state_type s_q;
  vir_top_state_type s_d;

  logic [`VIR_NUM_LINES-1:0] lines;
  logic [`VIR_NUM_LINES-1:0] rise;
  logic [`VIR_NUM_LINES*`VIR_CODE_W-1:0] sel_flat;
  logic req;
  logic take;
  logic hit_wr;
  logic hit_rd;

  // Byte lanes and the writable mask applied together; reserved bits stay zero
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wdata,
                                        input logic [3:0] be, input logic [31:0] mask);
    logic [31:0] lane;
    lane = '0;
    for (int b = 0; b < 4; b++) begin
      lane[b*8 +: 8] = {8{be[b]}};
    end
    merge = ((old & ~lane) | (wdata & lane)) & mask;
  endfunction : merge

  function automatic logic [`VIR_NUM_LINES-1:0] narrow(input logic [31:0] v);
    narrow = v[`VIR_NUM_LINES-1:0];
  endfunction : narrow

  function automatic logic [31:0] widen(input logic [`VIR_NUM_LINES-1:0] v);
    widen = {{(32-`VIR_NUM_LINES){1'b0}}, v};
  endfunction : widen

  ////////////////////////////////////////////////////////////////////////////////
  // Selector fan-out to the routed lines

  always_comb begin
    sel_flat = {s_q.evt_sel.sel3, s_q.evt_sel.sel2, s_q.evt_sel.sel1, s_q.evt_sel.sel0,
                s_q.irq_sel_c[`VIR_CODE_W-1:0],
                s_q.irq_sel_b.sel3, s_q.irq_sel_b.sel2, s_q.irq_sel_b.sel1, s_q.irq_sel_b.sel0};
  end

  for (genvar g = 0; g < `VIR_NUM_LINES; g++) begin : g_line
    vir_route_line vir_route_line_inst (
      .clk(clk),
      .rst(rst),
      .sel(sel_flat[g*`VIR_CODE_W +: `VIR_CODE_W]),
      .sources(irq_sources),
      .line_q(lines[g])
    );
  end

  vir_clock_ctrl vir_clock_ctrl_inst (
    .clk(clk),
    .rst(rst),
    .ctrl(s_q.clk_ctrl),
    .clk_out_q(clock_enables)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Bus slave and register state

  assign req = avs_read | avs_write;
  // One wait cycle: decode on the first cycle, complete on the second
  assign take = req & ~s_q.wait_r;
  assign rise = lines & ~s_q.lines_prev;

  always_comb begin
    s_d = s_q;
    hit_wr = 1'b0;
    hit_rd = 1'b0;
    s_d.lines_prev = lines;
    s_d.wait_r = ~(req & s_q.wait_r);

    if (avs_write & take) begin
      if (avs_address == `VIR_ADDR_CLK_CTRL) begin
        s_d.clk_ctrl = merge(s_q.clk_ctrl, avs_writedata, avs_byteenable, `VIR_MASK_CLK_CTRL);
        hit_wr = 1'b1;
      end else if (avs_address == `VIR_ADDR_IRQ_SEL_B) begin
        s_d.irq_sel_b = merge(s_q.irq_sel_b, avs_writedata, avs_byteenable, `VIR_MASK_SEL4);
        hit_wr = 1'b1;
      end else if (avs_address == `VIR_ADDR_IRQ_SEL_C) begin
        s_d.irq_sel_c = merge(s_q.irq_sel_c, avs_writedata, avs_byteenable, `VIR_MASK_SEL1);
        hit_wr = 1'b1;
      end else if (avs_address == `VIR_ADDR_EVT_SEL) begin
        s_d.evt_sel = merge(s_q.evt_sel, avs_writedata, avs_byteenable, `VIR_MASK_SEL4);
        hit_wr = 1'b1;
      end else if (avs_address == `VIR_ADDR_TBL_PRIO) begin
        s_d.prio = merge(s_q.prio, avs_writedata, avs_byteenable, `VIR_MASK_TBL_PRIO);
        hit_wr = 1'b1;
      end else if (avs_address == `VIR_ADDR_IRQ_MASK) begin
        s_d.mask = narrow(merge(widen(s_q.mask), avs_writedata, avs_byteenable, `VIR_MASK_IRQ));
        hit_wr = 1'b1;
      end else begin
        hit_wr = 1'b0;
      end
    end

    // Read data is latched on the wait cycle so it stands at the completing edge
    if (avs_read & s_q.wait_r) begin
      if (avs_address == `VIR_ADDR_CLK_CTRL) begin
        s_d.rdata = s_q.clk_ctrl;
        hit_rd = 1'b1;
      end else if (avs_address == `VIR_ADDR_IRQ_SEL_B) begin
        s_d.rdata = s_q.irq_sel_b;
        hit_rd = 1'b1;
      end else if (avs_address == `VIR_ADDR_IRQ_SEL_C) begin
        s_d.rdata = s_q.irq_sel_c;
        hit_rd = 1'b1;
      end else if (avs_address == `VIR_ADDR_EVT_SEL) begin
        s_d.rdata = s_q.evt_sel;
        hit_rd = 1'b1;
      end else if (avs_address == `VIR_ADDR_TBL_PRIO) begin
        s_d.rdata = s_q.prio;
        hit_rd = 1'b1;
      end else if (avs_address == `VIR_ADDR_IRQ_STATUS) begin
        s_d.rdata = widen(s_q.status | rise);
        hit_rd = 1'b1;
      end else if (avs_address == `VIR_ADDR_IRQ_MASK) begin
        s_d.rdata = widen(s_q.mask);
        hit_rd = 1'b1;
      end else begin
        s_d.rdata = `VIR_RST_ZERO;
        hit_rd = 1'b0;
      end
    end

    // Status clears on the completing read; a new rise in that cycle still sets
    if (avs_read & take & (avs_address == `VIR_ADDR_IRQ_STATUS)) begin
      s_d.status = rise;
    end else begin
      s_d.status = s_q.status | rise;
    end
    s_d.irq_out = |(s_d.status & s_d.mask);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.clk_ctrl <= `VIR_RST_CLK_CTRL;
      s_q.wait_r <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign avs_readdata = s_q.rdata;
  assign avs_waitrequest = s_q.wait_r;
  assign irq_lines = lines[`VIR_NUM_IRQ-1:0];
  assign event_lines = lines[`VIR_NUM_LINES-1:`VIR_NUM_IRQ];
  assign irq = s_q.irq_out;
  assign table_priority = s_q.prio;

endmodule : vir_route_ctrl

// ### vir_params.svh
// Constants of the video interrupt routing and clock control block
//
// Overview of operation
// - Second interrupt select register holds selectors for interrupt lines four to seven.
// - Third interrupt select register holds one selector for line eight; rest reserved.
// - Event select register holds selectors for event lines zero to three.
// - Codes 1 to 29 map to fixed internal sources; reserved codes select nothing.
// - Interrupt and event selectors share one source code map.
// - All selector fields are read/write, reset to zero; gaps read zero.
// - Priority register bit 24 enables RGB table copying; resets to zero.
// - Priority bits 20 to 4 and bit 1 set per-table memory priority; reset zero.
// - Priority bits 3 and 2 select lens-shading table memory access; reset zero.
// - Clock control bit 0 gates overlay and encoder clocks; resets to one.
// - Clock control bit 2 picks encoder clock undivided or halved; resets zero.
// - Clock control bit 3 enables the lens correction clock.
// - Clock control bit 6 gives overlay memory to overlay engine or host.
// - Clock control bit 7 gives lens memory to lens engine or host.
// - Clock control resets with bits 0, 3, 4 set; bits 1, 5 read zero.
`ifndef VIR_PARAMS_SVH
`define VIR_PARAMS_SVH

`define VIR_ADDR_W 8
`define VIR_ADDR_CLK_CTRL 8'h00
`define VIR_ADDR_IRQ_SEL_B 8'h14
`define VIR_ADDR_IRQ_SEL_C 8'h18
`define VIR_ADDR_EVT_SEL 8'h1c
`define VIR_ADDR_TBL_PRIO 8'h2c
`define VIR_ADDR_IRQ_STATUS 8'h30
`define VIR_ADDR_IRQ_MASK 8'h34

`define VIR_MASK_CLK_CTRL 32'h000000dd
`define VIR_RST_CLK_CTRL 32'h00000019
`define VIR_MASK_SEL4 32'h1f1f1f1f
`define VIR_MASK_SEL1 32'h0000001f
`define VIR_MASK_TBL_PRIO 32'h011ffffe
`define VIR_MASK_IRQ 32'h000001ff
`define VIR_RST_ZERO 32'h00000000

`define VIR_NUM_SRC 29
`define VIR_NUM_IRQ 5
`define VIR_NUM_EVT 4
`define VIR_NUM_LINES 9
`define VIR_CODE_W 5
`define VIR_CODE_RSV_A 5'h07
`define VIR_CODE_RSV_B 5'h0d
`define VIR_CODE_RSV_C 5'h12
`define VIR_CODE_RSV_D 5'h13
`define VIR_CODE_MAX 5'h1d
`define VIR_CODE_NONE 5'h00

`endif

// ### vir_pkg.sv
// Types of the video interrupt routing and clock control block
package vir_pkg;

  typedef struct packed {
    logic [2:0] rsv3;
    logic [4:0] sel3;
    logic [2:0] rsv2;
    logic [4:0] sel2;
    logic [2:0] rsv1;
    logic [4:0] sel1;
    logic [2:0] rsv0;
    logic [4:0] sel0;
  } vir_sel4_type;

  typedef struct packed {
    logic [6:0] rsv_top;
    logic rgb_table_copy_en;
    logic [2:0] rsv_mid;
    logic boxcar_table1_prio;
    logic boxcar_table0_prio;
    logic histogram_table3_prio;
    logic histogram_table2_prio;
    logic histogram_table1_prio;
    logic histogram_table0_prio;
    logic cube_lut3_prio;
    logic cube_lut2_prio;
    logic cube_lut1_prio;
    logic cube_lut0_prio;
    logic gain_table_prio;
    logic edge_enhance_table_prio;
    logic gamma_red_prio;
    logic gamma_green_prio;
    logic gamma_blue_prio;
    logic defect_table_prio;
    logic clamp_table_prio;
    logic shading_table1_sel;
    logic shading_table0_sel;
    logic linearization_table_prio;
    logic rsv_low;
  } vir_prio_type;

  typedef struct packed {
    logic [23:0] rsv_top;
    logic lens_memory_owner_sel;
    logic overlay_memory_owner_sel;
    logic rsv5;
    logic spare4;
    logic lens_correction_clock_gate;
    logic encoder_clock_divide_sel;
    logic rsv1;
    logic display_clock_gate;
  } vir_clk_ctrl_type;

  typedef struct packed {
    logic overlay_clk_en;
    logic encoder_clk_en;
    logic lens_clk_en;
    logic overlay_mem_clk_en;
    logic overlay_mem_to_host;
    logic lens_mem_clk_en;
    logic lens_mem_to_host;
  } vir_clk_out_type;

  typedef enum logic [1:0] {VIR_OWN_RUN, VIR_OWN_STOP, VIR_OWN_SWAP} vir_own_state_type;

endpackage : vir_pkg

// ### vir_route_line.sv
// One routed output line: picks a source by selector code
`timescale 1ns/1ps
`include "vir_params.svh"

module vir_route_line
  import vir_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [`VIR_CODE_W-1:0] sel,
  input wire logic [`VIR_NUM_SRC-1:0] sources,
  output logic line_q
);

  typedef struct packed {
    logic line;
  } vir_route_state_type;

  vir_route_state_type s_q;
  vir_route_state_type s_d;

  // Code n takes source n-1; same map for every line
  function automatic logic route(input logic [`VIR_CODE_W-1:0] code, input logic [`VIR_NUM_SRC-1:0] src);
    logic [`VIR_CODE_W-1:0] idx;
    idx = code - 5'h01;
    if (code == `VIR_CODE_NONE || code > `VIR_CODE_MAX) begin
      route = 1'b0;
    end else if (code == `VIR_CODE_RSV_A || code == `VIR_CODE_RSV_B ||
                 code == `VIR_CODE_RSV_C || code == `VIR_CODE_RSV_D) begin
      route = 1'b0;
    end else begin
      route = src[idx];
    end
  endfunction : route

  always_comb begin
    s_d = s_q;
    s_d.line = route(sel, sources);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign line_q = s_q.line;

endmodule : vir_route_line

// ### vir_clock_ctrl.sv
// Glitch-free clock enables, encoder divider and memory owner switching
`timescale 1ns/1ps
`include "vir_params.svh"

module vir_clock_ctrl
  import vir_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire vir_clk_ctrl_type ctrl,
  output vir_clk_out_type clk_out_q
);

  typedef struct packed {
    logic phase;
    vir_own_state_type [1:0] own_st;
    logic [1:0] owner;
    vir_clk_out_type out;
  } vir_clkc_state_type;

  vir_clkc_state_type s_q;
  vir_clkc_state_type s_d;
  logic [1:0] want;
  logic [1:0] gate;

  // Enables change only at clk edges, so gated clocks see whole cycles only
  always_comb begin
    s_d = s_q;
    want = {ctrl.lens_memory_owner_sel, ctrl.overlay_memory_owner_sel};
    gate = {ctrl.lens_correction_clock_gate, ctrl.display_clock_gate};
    s_d.phase = ~s_q.phase;
    s_d.out.overlay_clk_en = ctrl.display_clock_gate;
    s_d.out.encoder_clk_en = ctrl.display_clock_gate & (~ctrl.encoder_clock_divide_sel | s_q.phase);
    s_d.out.lens_clk_en = ctrl.lens_correction_clock_gate;
    // Break before make: memory clock stops one cycle each side of the swap
    for (int i = 0; i < 2; i++) begin
      case (s_q.own_st[i])
        VIR_OWN_RUN: begin
          if (want[i] != s_q.owner[i]) begin
            s_d.own_st[i] = VIR_OWN_STOP;
          end
        end
        VIR_OWN_STOP: begin
          s_d.owner[i] = want[i];
          s_d.own_st[i] = VIR_OWN_SWAP;
        end
        default: begin
          s_d.own_st[i] = VIR_OWN_RUN;
        end
      endcase
    end
    s_d.out.overlay_mem_to_host = s_d.owner[0];
    s_d.out.lens_mem_to_host = s_d.owner[1];
    s_d.out.overlay_mem_clk_en = (s_d.own_st[0] == VIR_OWN_RUN) & (gate[0] | s_d.owner[0]);
    s_d.out.lens_mem_clk_en = (s_d.own_st[1] == VIR_OWN_RUN) & (gate[1] | s_d.owner[1]);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.out.overlay_clk_en <= 1'b1;
      s_q.out.encoder_clk_en <= 1'b1;
      s_q.out.lens_clk_en <= 1'b1;
      s_q.out.overlay_mem_clk_en <= 1'b1;
      s_q.out.lens_mem_clk_en <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign clk_out_q = s_q.out;

endmodule : vir_clock_ctrl

// ### vir_route_ctrl_properties.sv
// Checker for the routing and clock control top
`timescale 1ns/1ps
`include "vir_params.svh"

module vir_route_ctrl_properties
  import vir_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [`VIR_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [`VIR_NUM_SRC-1:0] irq_sources,
  input wire logic [`VIR_NUM_IRQ-1:0] irq_lines,
  input wire logic [`VIR_NUM_EVT-1:0] event_lines,
  input wire logic irq,
  input wire vir_prio_type table_priority,
  input wire vir_clk_out_type clock_enables
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_read_done(logic [7:0] a);
    !avs_waitrequest && avs_read && avs_address == a;
  endsequence

  a_wait_one_cycle: assert property (s_req |=> !avs_waitrequest) else $error("wait not one cycle");
  a_wait_single_low: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("wait low too long");
  a_idle_wait_high: assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
    else $error("answer without request");
  a_ctrl_reserved_zero: assert property (s_read_done(`VIR_ADDR_CLK_CTRL) |->
    (avs_readdata & ~`VIR_MASK_CLK_CTRL) == 32'h00000000) else $error("clock ctrl reserved bits set");
  a_selc_reserved_zero: assert property (s_read_done(`VIR_ADDR_IRQ_SEL_C) |->
    avs_readdata[31:5] == 27'h0000000) else $error("line eight reserved bits set");
  a_unmapped_reads_zero: assert property (s_read_done(8'h04) |-> avs_readdata == 32'h00000000)
    else $error("unmapped read not zero");
  a_lines_quiet: assert property (irq_sources == 29'h00000000 |=> irq_lines == 5'h00 && event_lines == 4'h0)
    else $error("line active without source");
  a_prio_gaps_zero: assert property (table_priority.rsv_top == 7'h00 && table_priority.rsv_mid == 3'h0
    && !table_priority.rsv_low) else $error("priority gap bits set");
  a_ovl_owner_gap: assert property ($changed(clock_enables.overlay_mem_to_host) |->
    !clock_enables.overlay_mem_clk_en && !$past(clock_enables.overlay_mem_clk_en)) else $error("overlay swap glitch");
  a_lens_owner_gap: assert property ($changed(clock_enables.lens_mem_to_host) |->
    !clock_enables.lens_mem_clk_en && !$past(clock_enables.lens_mem_clk_en)) else $error("lens swap glitch");
  a_reset_clock_state: assert property (disable iff (1'b0) rst |=> clock_enables.overlay_clk_en
    && clock_enables.lens_clk_en && !clock_enables.overlay_mem_to_host && !clock_enables.lens_mem_to_host)
    else $error("clock outputs wrong in reset");
endmodule : vir_route_ctrl_properties

bind vir_route_ctrl vir_route_ctrl_properties vir_route_ctrl_properties_inst (.clk(clk), .rst(rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .irq_sources(irq_sources), .irq_lines(irq_lines), .event_lines(event_lines), .irq(irq),
  .table_priority(table_priority), .clock_enables(clock_enables));

// ### vir_engine_model.sv
// Video engines: interrupt source levels, prompt or one cycle late
`timescale 1ns/1ps

module vir_engine_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [28:0] want,
  input wire logic slow,
  output logic [28:0] irq_sources
);
  logic [28:0] stage_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      stage_q <= 29'h00000000;
      irq_sources <= 29'h00000000;
    end else begin
      stage_q <= want;
      irq_sources <= slow ? stage_q : want;
    end
  end
endmodule : vir_engine_model

// ### vir_route_ctrl_bench.sv
// Self-checking bench of the routing and clock control top
`timescale 1ns/1ps
`include "vir_params.svh"

module vir_route_ctrl_bench
  import vir_pkg::*;
;
  logic clk, rst, rd, wr, wait_r, irq, slow, e;
  logic [7:0] adr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] be, el, lanes;
  logic [4:0] il;
  logic [4:0] c [9];
  logic [8:0] exp;
  logic [28:0] want, src;
  vir_prio_type prio;
  vir_clk_out_type ce;
  logic [7:0] addrs [4] = '{8'h14, 8'h18, 8'h1c, 8'h2c};
  logic [31:0] msk [4] = '{`VIR_MASK_SEL4, `VIR_MASK_SEL1, `VIR_MASK_SEL4, `VIR_MASK_TBL_PRIO};
  int seed = 29;
  int mismatches = 0;
  int comparisons = 0;

  vir_route_ctrl vir_route_ctrl_inst (.clk(clk), .rst(rst), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(wait_r),
    .irq_sources(src), .irq_lines(il), .event_lines(el), .irq(irq), .table_priority(prio), .clock_enables(ce));
  vir_engine_model vir_engine_model_inst (.clk(clk), .rst(rst), .want(want), .slow(slow), .irq_sources(src));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    if (mismatches == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim

  task automatic check_word(input logic [31:0] got, input logic [31:0] want_v);
    comparisons++;
    if (got !== want_v) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, want_v);
    end
  endtask : check_word

  // Request held until waitrequest is seen low at a rising edge; data taken at that edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wr <= w;
    rd <= !w;
    wdata <= wd;
    be <= lanes;
    @(posedge clk);
    while (wait_r !== 1'b0 && n < 100) begin
      @(posedge clk);
      n++;
    end
    if (n == 100) mismatches++;
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  task automatic wr32(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] q;
    bus(1'b1, a, wd, q);
  endtask : wr32

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q;
    bus(1'b0, a, 32'h00000000, q);
    check_word(q, x);
  endtask : rd_chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // Reserved and unused codes keep the line low
  function automatic logic route(input logic [4:0] cd, input logic [28:0] s);
    if (cd == 5'h00 || cd > 5'h1d || cd == 5'h07 || cd == 5'h0d || cd == 5'h12 || cd == 5'h13) return 1'b0;
    return s[cd - 5'h01];
  endfunction : route

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_sim();
  end

  initial begin
    rst = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    adr = 8'h00;
    wdata = 32'h00000000;
    be = 4'hf;
    lanes = 4'hf;
    want = 29'h00000000;
    slow = 1'b0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd_chk(8'h00, `VIR_RST_CLK_CTRL);
    check_word({25'h0, ce}, 32'h0000007a);
    for (int i = 0; i < 4; i++) rd_chk(addrs[i], 32'h00000000);
    rd_chk(8'h04, 32'h00000000);
    for (int i = 0; i < 4; i++) begin
      d = $random(seed);
      wr32(addrs[i], msk[i]);
      rd_chk(addrs[i], msk[i]);
      wr32(addrs[i], d & msk[i]);
      rd_chk(addrs[i], d & msk[i]);
    end
    check_word(prio, d & msk[3]);
    wr32(8'h2c, 32'h0100000c);
    tick(2);
    check_word(prio, 32'h0100000c);
    // Only the low byte lane may change
    lanes = 4'h1;
    wr32(8'h2c, `VIR_MASK_TBL_PRIO);
    lanes = 4'hf;
    rd_chk(8'h2c, 32'h010000fe);
    wr32(8'h00, 32'h00000000);
    tick(5);
    check_word({25'h0, ce}, 32'h00000000);
    wr32(8'h00, 32'h00000040);
    tick(5);
    check_word({25'h0, ce}, 32'h0000000c);
    wr32(8'h00, 32'h00000085);
    tick(5);
    e = ce.encoder_clk_en;
    check_word({25'h0, ce & 7'h5f}, 32'h0000004b);
    tick(1);
    check_word({31'h0, ce.encoder_clk_en ^ e}, 32'h00000001);
    // Sweep of all codes spread across the nine lines, then random codes
    for (int k = 0; k < 12; k++) begin
      for (int i = 0; i < 9; i++) c[i] = (k < 4) ? 5'(k * 9 + i) : 5'($random(seed));
      want <= 29'($random(seed));
      slow <= k[0];
      wr32(8'h14, {3'h0, c[3], 3'h0, c[2], 3'h0, c[1], 3'h0, c[0]});
      wr32(8'h18, {27'h0, c[4]});
      wr32(8'h1c, {3'h0, c[8], 3'h0, c[7], 3'h0, c[6], 3'h0, c[5]});
      tick(4);
      for (int i = 0; i < 9; i++) exp[i] = route(c[i], want);
      check_word({23'h0, el, il}, {23'h0, exp});
    end
    want <= 29'h00000000;
    wr32(8'h14, 32'h00000001);
    wr32(8'h18, 32'h00000000);
    wr32(8'h1c, 32'h00000000);
    tick(4);
    bus(1'b0, 8'h30, 32'h00000000, d);
    want <= 29'h00000001;
    tick(4);
    check_word({31'h0, irq}, 32'h00000000);
    wr32(8'h34, 32'h00000001);
    tick(2);
    check_word({31'h0, irq}, 32'h00000001);
    rd_chk(8'h30, 32'h00000001);
    tick(2);
    check_word({31'h0, irq}, 32'h00000000);
    rd_chk(8'h34, 32'h00000001);
    end_sim();
  end
endmodule : vir_route_ctrl_bench
